// *** gcsl_glue.sv ***
// system support glue: interrupt gathering, dram/rom decode, bus strobes, dma handshake,
// keyboard capture, speaker and floppy support signals.
// assumes bus status and all pins are asynchronous to clk_sys; the timer,
// dma and floppy cores sit outside and reach this block through plain pins.
`timescale 1ns/1ns
`include "gcsl_defs.svh"
module gcsl_glue (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [19:0] bus_addr,
  input wire logic [7:0] bus_data_in,
  input wire logic cyc_mem,
  input wire logic cyc_io,
  input wire logic cyc_rd,
  input wire logic cyc_wr,
  input wire logic cyc_refresh,
  input wire logic io_ready_in,
  input wire logic channel_ready_in,
  input wire logic [7:2] ext_irq,
  input wire logic timer_out0,
  input wire logic timer_out2,
  input wire logic [3:1] dma_request_lines,
  input wire logic dma_last_transfer,
  input wire logic keyboard_serial_in,
  input wire logic keyboard_shift_clock,
  input wire logic speaker_feedback_in,
  input wire logic fdc_int_in,
  input wire logic fdc_dma_in,
  input wire logic fdc_head_in,
  input wire logic clk16_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe_b,
  output logic cpu_ready,
  output logic dma_ready,
  output logic intr_req,
  output logic common_row_strobe,
  output logic bank0_row_strobe,
  output logic bank1_row_strobe,
  output logic bank2_row_strobe,
  output logic rom_low_read_enable,
  output logic rom_high_read_enable,
  output logic io_read_strobe,
  output logic io_write_strobe,
  output logic mem_read_strobe,
  output logic mem_write_strobe,
  output logic [3:1] dma_acknowledge_lines,
  output logic dma_bus_owned,
  output logic terminal_count_out,
  output logic keyboard_interrupt_req,
  output logic speaker_tone,
  output logic speaker_gate,
  output logic ext_buffer_enable,
  output logic ext_buffer_direction,
  output logic mem_buffer_enable,
  output logic spindle_motor_on,
  output logic drive_select_one,
  output logic drive_select_two,
  output logic floppy_ctrl_clock,
  output logic head_side_select,
  output logic floppy_dma_request,
  output logic floppy_write_clock
);
  import gcsl_pkg::*;

  gcsl_pkg::gcsl_state_t st_r, st_nxt;
  logic [32:0] bus_s;
  logic [20:0] misc_s;
  logic [19:0] a;
  logic [15:0] ioa;
  logic [7:0] din;
  logic s_mem, s_io, s_rd, s_wr, s_ref;
  logic s_iordy, s_chrdy, s_t0, s_t2, s_dlast, s_kdat, s_kclk, s_spk, s_fint, s_freq, s_fhead, s_c16;
  logic [7:2] s_irq;
  logic [3:1] s_dreq;
  logic wclk_tick;

  // every pin but clk_sys and rst_b passes two flops before use
  gcsl_sync #(.W(33)) u_bus_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d({bus_addr, bus_data_in, cyc_mem, cyc_io, cyc_rd, cyc_wr, cyc_refresh}),
    .q(bus_s)
  );

  gcsl_sync #(.W(21)) u_misc_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d({io_ready_in, channel_ready_in, ext_irq, timer_out0, timer_out2, dma_request_lines,
        dma_last_transfer, keyboard_serial_in, keyboard_shift_clock, speaker_feedback_in,
        fdc_int_in, fdc_dma_in, fdc_head_in, clk16_in}),
    .q(misc_s)
  );

  assign {a, din, s_mem, s_io, s_rd, s_wr, s_ref} = bus_s;
  assign {s_iordy, s_chrdy, s_irq, s_t0, s_t2, s_dreq, s_dlast, s_kdat, s_kclk, s_spk,
          s_fint, s_freq, s_fhead, s_c16} = misc_s;
  assign ioa = a[15:0];

  // write clock half-periods counted in 16 mhz edges
  gcsl_tick_div #(.N(`GCSL_WCLK_HALF)) u_wclk_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .en_in(s_c16 && !st_r.c16_d),
    .tick(wclk_tick)
  );

  // any port that this device answers itself
  function automatic logic gcsl_internal_io(input logic [15:0] p);
    gcsl_internal_io = (p <= `GCSL_IO_DMA_HI) || (p == `GCSL_IO_IMASK) ||
      (p >= `GCSL_IO_TMR_LO && p <= `GCSL_IO_TMR_HI) ||
      (p >= `GCSL_IO_PORTA && p <= `GCSL_IO_PPI_HI) ||
      (p >= `GCSL_IO_PAGE_LO && p <= `GCSL_IO_PAGE_HI) || (p == `GCSL_IO_NMI) ||
      (p >= `GCSL_IO_PRT_LO && p <= `GCSL_IO_PRT_HI) ||
      ((p & `GCSL_IO_FD_MASK) == `GCSL_IO_FDC) || ((p & `GCSL_IO_FD_MASK) == `GCSL_IO_FDO);
  endfunction

  // whole next state; outputs are fields of it so every output is a flop
  always_comb begin
    logic io_wr_go, io_rd_int, kfall, cpu_cyc, any_cyc;
    logic [3:1] reqs;
    logic [7:0] lvl;
    reqs = '0;
    lvl = '0;
    io_wr_go = s_io && s_wr && !st_r.wr_d && !st_r.owned;
    io_rd_int = s_io && s_rd && !st_r.owned && gcsl_internal_io(ioa);
    kfall = st_r.keyboard_shift_clock_d && !s_kclk;
    any_cyc = s_mem || s_io || s_ref;
    cpu_cyc = any_cyc && !st_r.owned;
    st_nxt = st_r;
    st_nxt.rd_d = s_io && s_rd;
    st_nxt.wr_d = s_io && s_wr;
    st_nxt.keyboard_shift_clock_d = s_kclk;
    st_nxt.fint_d = s_fint;
    st_nxt.freq_d = s_freq;
    st_nxt.c16_d = s_c16;

    // register writes, taken on the leading edge of the cpu write strobe
    if (io_wr_go) begin
      if (ioa == `GCSL_IO_PORTB) begin
        st_nxt.port_b = din;
      end
      if (ioa == `GCSL_IO_IMASK) begin
        st_nxt.imask = din;
      end
      if ((ioa & `GCSL_IO_FD_MASK) == `GCSL_IO_FDO) begin
        st_nxt.fdo = din;
      end
    end

    // register reads drive the data pins while the read stands
    st_nxt.doe_b = !(io_rd_int && (ioa == `GCSL_IO_PORTA || ioa == `GCSL_IO_PORTB ||
                     ioa == `GCSL_IO_PORTC || ioa == `GCSL_IO_IMASK));
    case (ioa)
      `GCSL_IO_PORTA: st_nxt.dout = st_r.kbd_data;
      `GCSL_IO_PORTB: st_nxt.dout = st_r.port_b;
      `GCSL_IO_PORTC: st_nxt.dout = 8'(s_spk) << `GCSL_PC_SPKFB;
      `GCSL_IO_IMASK: st_nxt.dout = st_r.imask;
      default: st_nxt.dout = 8'h00;
    endcase

    // keyboard capture; lsb first after the start bit, frozen while blocked or full
    if (kfall && !st_r.port_b[`GCSL_PB_KBLOCK] && !st_r.kbd_irq) begin
      st_nxt.kbd_shift = {s_kdat, st_r.kbd_shift[7:1]};
      if (st_r.kbd_cnt == `GCSL_KBD_BITS - 4'h1) begin
        st_nxt.kbd_cnt = 4'h0;
        st_nxt.kbd_data = {s_kdat, st_r.kbd_shift[7:1]};
      end else begin
        st_nxt.kbd_cnt = st_r.kbd_cnt + 4'h1;
      end
    end
    // the clear falls on a clock edge; a completing byte wins over it
    if (st_r.port_b[`GCSL_PB_KBCLR]) begin
      st_nxt.kbd_irq = 1'b0;
      st_nxt.kbd_cnt = 4'h0;
    end
    if (kfall && !st_r.port_b[`GCSL_PB_KBLOCK] && !st_r.kbd_irq &&
        st_r.kbd_cnt == `GCSL_KBD_BITS - 4'h1) begin
      st_nxt.kbd_irq = 1'b1;
    end

    // floppy interrupt latched on its rising edge, cleared by controller access
    if (s_io && (s_rd || s_wr) && !st_r.owned && (ioa & `GCSL_IO_FD_MASK) == `GCSL_IO_FDC) begin
      st_nxt.fint_flag = 1'b0;
    end
    if (s_fint && !st_r.fint_d) begin
      st_nxt.fint_flag = 1'b1;
    end

    // floppy dma request, dropped when channel two is acknowledged
    if (st_r.dack[2]) begin
      st_nxt.freq_flag = 1'b0;
    end
    if (s_freq && !st_r.freq_d) begin
      st_nxt.freq_flag = 1'b1;
    end

    // interrupt levels through the mask
    lvl = {s_irq[7], s_irq[6] || st_r.fint_flag, s_irq[5:2], st_r.kbd_irq, s_t0};
    st_nxt.intr = |(lvl & ~st_r.imask);

    // dma arbiter: lowest channel first, only between bus cycles
    reqs = {s_dreq[3], s_dreq[2] || st_r.freq_flag, s_dreq[1]};
    case (st_r.dma_st)
      GCSL_DMA_IDLE: begin
        if (|reqs && !any_cyc) begin
          st_nxt.dma_st = GCSL_DMA_GRANT;
          st_nxt.owned = 1'b1;
          st_nxt.dack = reqs[1] ? 3'b001 : (reqs[2] ? 3'b010 : 3'b100);
        end
      end
      GCSL_DMA_GRANT: begin
        if (!(|(reqs & st_r.dack)) || st_r.tc) begin
          st_nxt.dma_st = GCSL_DMA_IDLE;
          st_nxt.owned = 1'b0;
          st_nxt.dack = 3'b000;
        end
      end
      default: begin
        st_nxt.dma_st = GCSL_DMA_IDLE;
        st_nxt.owned = 1'b0;
        st_nxt.dack = 3'b000;
      end
    endcase
    st_nxt.tc = st_r.owned && s_dlast && !st_r.tc;

    // ready: low while either ready pin is low
    st_nxt.cpu_rdy = cpu_cyc && s_iordy && s_chrdy;
    st_nxt.dma_rdy = st_r.owned && any_cyc && s_iordy && s_chrdy;

    // memory decode, registered so it moves only on clock edges
    st_nxt.cras = s_mem || s_ref;
    st_nxt.ras[0] = s_ref || (s_mem && a <= `GCSL_BANK0_HI);
    st_nxt.ras[1] = s_ref || (s_mem && a > `GCSL_BANK0_HI && a <= `GCSL_BANK1_HI);
    st_nxt.ras[2] = s_ref || (s_mem && a > `GCSL_BANK1_HI && a <= `GCSL_BANK2_HI);
    st_nxt.roe[0] = s_mem && s_rd && !s_ref && a >= `GCSL_ROM0_LO && a < `GCSL_ROM1_LO;
    st_nxt.roe[1] = s_mem && s_rd && !s_ref && a >= `GCSL_ROM1_LO;
    st_nxt.mbuf_en = s_mem && !s_ref && a <= `GCSL_BANK2_HI;
    st_nxt.strb = {s_io && s_rd, s_io && s_wr, s_mem && s_rd, s_mem && s_wr};

    // external buffer: off only for cpu reads of our own ports
    st_nxt.ebuf_en = !io_rd_int;
    st_nxt.ebuf_dir = !(s_rd && !st_r.owned);

    // speaker and floppy support pins
    st_nxt.spk_tone = s_t2;
    st_nxt.spk_gate = st_r.port_b[`GCSL_PB_SPK];
    st_nxt.motor = st_r.fdo[`GCSL_FDO_MOT0] || st_r.fdo[`GCSL_FDO_MOT1];
    st_nxt.dsel[0] = st_r.fdo[`GCSL_FDO_MOT0] && !st_r.fdo[`GCSL_FDO_SEL1] &&
                     !st_r.fdo[`GCSL_FDO_SEL0];
    st_nxt.dsel[1] = st_r.fdo[`GCSL_FDO_MOT1] && st_r.fdo[`GCSL_FDO_SEL0] &&
                     !st_r.fdo[`GCSL_FDO_SEL1];
    st_nxt.side = s_fhead;
    if (s_c16 && !st_r.c16_d) begin
      st_nxt.fclk = !st_r.fclk;
    end
    if (wclk_tick) begin
      st_nxt.wclk = !st_r.wclk;
    end
  end

  // mask comes up all set so nothing interrupts before software opens it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.port_b <= `GCSL_PB_RST;
      st_r.fdo <= `GCSL_FDO_RST;
      st_r.imask <= `GCSL_IMASK_RST;
      st_r.doe_b <= 1'b1;
      st_r.ebuf_en <= 1'b1;
      st_r.ebuf_dir <= 1'b1;
      st_r.dma_st <= GCSL_DMA_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_data_out = st_r.dout;
  assign bus_data_oe_b = st_r.doe_b;
  assign cpu_ready = st_r.cpu_rdy;
  assign dma_ready = st_r.dma_rdy;
  assign intr_req = st_r.intr;
  assign common_row_strobe = st_r.cras;
  assign {bank2_row_strobe, bank1_row_strobe, bank0_row_strobe} = st_r.ras;
  assign {rom_high_read_enable, rom_low_read_enable} = st_r.roe;
  assign {io_read_strobe, io_write_strobe, mem_read_strobe, mem_write_strobe} = st_r.strb;
  assign dma_acknowledge_lines = st_r.dack;
  assign dma_bus_owned = st_r.owned;
  assign terminal_count_out = st_r.tc;
  assign keyboard_interrupt_req = st_r.kbd_irq;
  assign speaker_tone = st_r.spk_tone;
  assign speaker_gate = st_r.spk_gate;
  assign ext_buffer_enable = st_r.ebuf_en;
  assign ext_buffer_direction = st_r.ebuf_dir;
  assign mem_buffer_enable = st_r.mbuf_en;
  assign spindle_motor_on = st_r.motor;
  assign {drive_select_two, drive_select_one} = st_r.dsel;
  assign floppy_ctrl_clock = st_r.fclk;
  assign head_side_select = st_r.side;
  assign floppy_dma_request = st_r.freq_flag;
  assign floppy_write_clock = st_r.wclk;

  // checks on the registered outputs against their synchronised causes
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_refresh_all_banks: assert property (s_ref |=> (bank0_row_strobe && bank1_row_strobe && bank2_row_strobe
    && common_row_strobe && !mem_buffer_enable)) else $error("refresh banks wrong");
  a_bank_one_decode: assert property (s_mem && !s_ref && a > `GCSL_BANK0_HI && a <= `GCSL_BANK1_HI
    |=> bank1_row_strobe && !bank0_row_strobe && !bank2_row_strobe) else $error("bank one decode");
  a_rom_high_decode: assert property (rom_high_read_enable |-> $past(s_rd) && $past(a) >= `GCSL_ROM1_LO)
    else $error("rom high enable without high read");
  a_cras_follows: assert property ((s_mem || s_ref) |=> common_row_strobe) else $error("row strobe missing");
  a_motor_bits: assert property (##1 spindle_motor_on == $past(st_r.fdo[`GCSL_FDO_MOT0]
    || st_r.fdo[`GCSL_FDO_MOT1])) else $error("motor mismatch");
  a_drive_sel_two: assert property (drive_select_two |-> $past(st_r.fdo[`GCSL_FDO_MOT1])
    && !$past(st_r.fdo[`GCSL_FDO_SEL1]) && !drive_select_one) else $error("select two wrong");
  a_kbd_block_hold: assert property (st_r.port_b[`GCSL_PB_KBLOCK] && !st_r.port_b[`GCSL_PB_KBCLR]
    |=> $stable(st_r.kbd_shift) && $stable(st_r.kbd_cnt)) else $error("keyboard shifted while blocked");
  a_kbd_irq_rise: assert property ($rose(keyboard_interrupt_req) |-> $past(st_r.kbd_cnt) == `GCSL_KBD_BITS - 4'h1)
    else $error("keyboard request before full byte");
  a_fdc_int_clear: assert property (s_io && s_rd && !st_r.owned && (ioa & `GCSL_IO_FD_MASK) == `GCSL_IO_FDC
    && !(s_fint && !st_r.fint_d) |=> !st_r.fint_flag) else $error("floppy interrupt not cleared");
  a_freq_drop_ack: assert property (dma_acknowledge_lines[2] && !(s_freq && !st_r.freq_d)
    |=> !floppy_dma_request) else $error("floppy request stays after ack");
  a_ack_owns_bus: assert property (|dma_acknowledge_lines |-> dma_bus_owned && $onehot(dma_acknowledge_lines))
    else $error("ack without bus ownership");
  a_ready_waits: assert property (!s_iordy |=> !cpu_ready && !dma_ready) else $error("ready while held off");
  a_buffer_off_read: assert property (s_io && s_rd && !st_r.owned && ioa == `GCSL_IO_PORTB
    |=> !ext_buffer_enable) else $error("buffer on during internal read");
  a_intr_timer: assert property (s_t0 && !st_r.imask[0] |=> intr_req) else $error("timer level not raised");

  c_refresh: cover property (s_ref ##1 bank2_row_strobe);
  c_kbd_byte: cover property ($rose(keyboard_interrupt_req));
  c_dma_grant: cover property ($rose(dma_bus_owned) ##[1:20] terminal_count_out);
  c_fdc_clear: cover property ($fell(st_r.fint_flag));
endmodule

// *** gcsl_defs.svh ***
// constants of the system support glue block: port addresses, bit positions,
// memory windows and clock ratios; included by the package and the glue module
`ifndef GCSL_DEFS_SVH
`define GCSL_DEFS_SVH

// i/o ports that live inside the device
`define GCSL_IO_DMA_LO 16'h0000
`define GCSL_IO_DMA_HI 16'h000f
`define GCSL_IO_IMASK 16'h0021
`define GCSL_IO_TMR_LO 16'h0040
`define GCSL_IO_TMR_HI 16'h0043
`define GCSL_IO_PORTA 16'h0060
`define GCSL_IO_PORTB 16'h0061
`define GCSL_IO_PORTC 16'h0062
`define GCSL_IO_PPI_HI 16'h0063
`define GCSL_IO_PAGE_LO 16'h0081
`define GCSL_IO_PAGE_HI 16'h0083
`define GCSL_IO_NMI 16'h00a0
`define GCSL_IO_PRT_LO 16'h0378
`define GCSL_IO_PRT_HI 16'h037f
`define GCSL_IO_FDC 16'h03f0
`define GCSL_IO_FDO 16'h03f2
`define GCSL_IO_FD_MASK 16'hfffa

// register bits
`define GCSL_PB_SPK 1
`define GCSL_PB_KBLOCK 6
`define GCSL_PB_KBCLR 7
`define GCSL_PC_SPKFB 4
`define GCSL_FDO_SEL0 0
`define GCSL_FDO_SEL1 1
`define GCSL_FDO_MOT0 4
`define GCSL_FDO_MOT1 5
`define GCSL_PB_RST 8'h00
`define GCSL_FDO_RST 8'h00
`define GCSL_IMASK_RST 8'hff
`define GCSL_FDC_IRQ 6

// memory windows
`define GCSL_BANK0_HI 20'h3ffff
`define GCSL_BANK1_HI 20'h7ffff
`define GCSL_BANK2_HI 20'h9ffff
`define GCSL_ROM0_LO 20'hf0000
`define GCSL_ROM1_LO 20'hf8000

// keyboard frame: start bit then eight data bits
`define GCSL_KBD_BITS 4'h9

// floppy write clock from the 16 mhz pin
`define GCSL_FIN_KHZ 16000
`define GCSL_WCLK_KHZ 500
`define GCSL_WCLK_HALF ((`GCSL_FIN_KHZ / `GCSL_WCLK_KHZ) / 2)

`endif

// *** gcsl_pkg.sv ***
// types shared by the glue modules
// assumes gcsl_defs.svh is reachable on the include path
package gcsl_pkg;
  `include "gcsl_defs.svh"

  typedef enum logic [0:0] {GCSL_DMA_IDLE, GCSL_DMA_GRANT} gcsl_dma_st_t;

  typedef struct packed {
    logic [7:0] port_b;
    logic [7:0] fdo;
    logic [7:0] imask;
    logic [7:0] kbd_shift;
    logic [7:0] kbd_data;
    logic [3:0] kbd_cnt;
    logic kbd_irq;
    logic keyboard_shift_clock_d;
    logic fint_flag;
    logic fint_d;
    logic freq_flag;
    logic freq_d;
    logic rd_d;
    logic wr_d;
    logic c16_d;
    gcsl_dma_st_t dma_st;
    logic [3:1] dack;
    logic owned;
    logic tc;
    logic [7:0] dout;
    logic doe_b;
    logic cpu_rdy;
    logic dma_rdy;
    logic intr;
    logic cras;
    logic [2:0] ras;
    logic [1:0] roe;
    logic [3:0] strb;
    logic ebuf_en;
    logic ebuf_dir;
    logic mbuf_en;
    logic spk_tone;
    logic spk_gate;
    logic motor;
    logic [1:0] dsel;
    logic fclk;
    logic side;
    logic wclk;
  } gcsl_state_t;
endpackage

// *** gcsl_sync.sv ***
// two-flop synchroniser for a group of pins
// assumes the pins are stable levels relative to the sampling clock
`timescale 1ns/1ns
module gcsl_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } gcsl_sync_st_t;

  gcsl_sync_st_t st_r, st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt.meta = d;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.sync;
endmodule

// *** gcsl_tick_div.sv ***
// enable-pulse divider: one tick every n input enables
// assumes en_in is a one-cycle pulse on clk_sys
`timescale 1ns/1ns
module gcsl_tick_div #(
  parameter int N = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic en_in,
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } gcsl_div_st_t;

  localparam logic [7:0] LAST = 8'(N - 1);

  gcsl_div_st_t st_r, st_nxt;

  // count enables, wrap and pulse on the last one
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (en_in) begin
      if (st_r.cnt == LAST) begin
        st_nxt.cnt = 8'h00;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule

// *** gcsl_kbd_model.sv ***
// keyboard sender on the far side of the keyboard pins
// assumes the bench raises kb_go for one cycle to start a frame
`timescale 1ns/1ns
module gcsl_kbd_model (
  input wire logic clk_sys,
  input wire logic kb_go,
  input wire logic [7:0] kbyte,
  output logic keyboard_shift_clock,
  output logic keyboard_serial_in,
  output logic kb_busy
);
  // clock rests high between frames, data line is pulled up
  initial begin
    keyboard_shift_clock = 1'b1;
    keyboard_serial_in = 1'b1;
    kb_busy = 1'b0;
  end
  // start bit then eight bits lsb first; slow edges so the syncs see every one
  always @(posedge kb_go) begin
    kb_busy = 1'b1;
    for (int i = 0; i < 9; i++) begin
      keyboard_serial_in = (i == 0) ? 1'b0 : kbyte[i-1];
      repeat (6) @(posedge clk_sys);
      #1 keyboard_shift_clock = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1 keyboard_shift_clock = 1'b1;
    end
    keyboard_serial_in = 1'b1;
    kb_busy = 1'b0;
  end
endmodule

// *** tb_system_support_glue_logic.sv ***
// self-checking bench for the glue block with a keyboard sender beside it
// assumes the package, defs header and keyboard model are compiled first
`timescale 1ns/1ns
module tb_system_support_glue_logic;
  import gcsl_pkg::*;
  logic clk_sys, rst_b, clk16_in, kb_go, kb_busy, keyboard_shift_clock, keyboard_serial_in, oe_v, en_v, dir_v;
  logic [19:0] bus_addr;
  logic [7:0] bus_data_in, kbyte, rd_val, bus_data_out;
  logic cyc_mem, cyc_io, cyc_rd, cyc_wr, cyc_refresh, io_ready_in, channel_ready_in, timer_out0, timer_out2;
  logic dma_last_transfer, speaker_feedback_in, fdc_int_in, fdc_dma_in, fdc_head_in, bus_data_oe_b, cpu_ready;
  logic [7:2] ext_irq;
  logic [3:1] dma_request_lines, dma_acknowledge_lines;
  logic dma_ready, intr_req, common_row_strobe, bank0_row_strobe, bank1_row_strobe, bank2_row_strobe;
  logic rom_low_read_enable, rom_high_read_enable, io_read_strobe, io_write_strobe, mem_read_strobe;
  logic mem_write_strobe, dma_bus_owned, terminal_count_out, keyboard_interrupt_req, speaker_tone, speaker_gate;
  logic ext_buffer_enable, ext_buffer_direction, mem_buffer_enable, spindle_motor_on, drive_select_one;
  logic drive_select_two, floppy_ctrl_clock, head_side_select, floppy_dma_request, floppy_write_clock;
  int n_errors = 0, check_count = 0, nf = 0, nw = 0;
  // addr, mem io rd wr refresh; cras, ras 2..0, rom hi lo, iord iowr merd mewr, mem buffer
  logic [35:0] rows [11] = '{
    {20'h00010, 5'b10100, 11'b1_001_00_0010_1}, {20'h3ffff, 5'b10010, 11'b1_001_00_0001_1},
    {20'h40000, 5'b10100, 11'b1_010_00_0010_1}, {20'h9ffff, 5'b10010, 11'b1_100_00_0001_1},
    {20'ha0000, 5'b10100, 11'b1_000_00_0010_0}, {20'hf7fff, 5'b10100, 11'b1_000_01_0010_0},
    {20'hf8000, 5'b10100, 11'b1_000_10_0010_0}, {20'hf8000, 5'b10010, 11'b1_000_00_0001_0},
    {20'hf8000, 5'b00001, 11'b1_111_00_0000_0}, {20'hff300, 5'b01100, 11'b0_000_00_1000_0},
    {20'hff300, 5'b01010, 11'b0_000_00_0100_0}};
  // motor, select one, select two beside the floppy output byte
  logic [10:0] fdo [5] = '{{3'b110, 8'h10}, {3'b101, 8'h21}, {3'b100, 8'h12}, {3'b101, 8'h31}, {3'b000, 8'h01}};

  gcsl_glue DUT (.*);
  gcsl_kbd_model kbd (.*);

  // 250 mhz system clock and an unrelated 16 mhz pin clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = !clk_sys;
  end
  initial begin
    clk16_in = 1'b0;
    forever #31 clk16_in = !clk16_in;
  end
  always @(floppy_ctrl_clock) nf++;
  always @(floppy_write_clock) nw++;
  // a hang costs a mismatch and ends the run
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one io cycle held past the sync pipeline, with the read side captured
  task automatic io(logic [15:0] a, logic w, logic [7:0] d);
    bus_addr = {4'h0, a};
    bus_data_in = d;
    {cyc_io, cyc_rd, cyc_wr} = {1'b1, !w, w};
    tick(4);
    {rd_val, oe_v, en_v, dir_v} = {bus_data_out, bus_data_oe_b, ext_buffer_enable, ext_buffer_direction};
    {cyc_io, cyc_rd, cyc_wr} = 3'b000;
    tick(4);
  endtask
  task automatic send(logic [7:0] b);
    kbyte = b;
    kb_go = 1'b1;
    tick(1);
    kb_go = 1'b0;
    for (int i = 0; i < 200 && kb_busy; i++) tick(1);
    if (kb_busy) begin
      n_errors++;
      complete_run();
    end
    tick(4);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    {rst_b, bus_addr, bus_data_in, kbyte, kb_go, cyc_mem, cyc_io, cyc_rd, cyc_wr, cyc_refresh} = '0;
    {timer_out0, timer_out2, dma_last_transfer, speaker_feedback_in, fdc_int_in, fdc_dma_in, fdc_head_in} = '0;
    {ext_irq, dma_request_lines, io_ready_in, channel_ready_in} = 11'h003;
    tick(12);
    chk({bus_data_oe_b, ext_buffer_enable, ext_buffer_direction, intr_req, spindle_motor_on}, 5'b11100, "reset");
    rst_b = 1'b1;
    tick(2);
    // decode table, one cycle per row with idle gaps between
    foreach (rows[i]) begin
      {bus_addr, cyc_mem, cyc_io, cyc_rd, cyc_wr, cyc_refresh} = rows[i][35:11];
      tick(4);
      chk({common_row_strobe, bank2_row_strobe, bank1_row_strobe, bank0_row_strobe, rom_high_read_enable,
        rom_low_read_enable, io_read_strobe, io_write_strobe, mem_read_strobe, mem_write_strobe,
        mem_buffer_enable}, rows[i][10:0], "decode");
      {cyc_mem, cyc_io, cyc_rd, cyc_wr, cyc_refresh} = 5'b00000;
      tick(4);
    end
    // speaker gate, tone and feedback
    io(16'h0061, 1'b1, 8'h02);
    {timer_out2, speaker_feedback_in} = 2'b11;
    tick(4);
    chk({speaker_gate, speaker_tone}, 2'b11, "speaker");
    io(16'h0062, 1'b0, 8'h00);
    chk({oe_v, en_v, dir_v, rd_val[4]}, 4'b0001, "port c");
    io(16'h0061, 1'b0, 8'h00);
    chk(rd_val, 8'h02, "port b");
    foreach (fdo[i]) begin
      io(16'h03f2, 1'b1, fdo[i][7:0]);
      chk({spindle_motor_on, drive_select_one, drive_select_two}, fdo[i][10:8], "drive");
    end
    // interrupt gathering and masking
    io(16'h0021, 1'b1, 8'h00);
    ext_irq = 6'b000010;
    tick(4);
    chk(intr_req, 1'b1, "irq3");
    io(16'h0021, 1'b1, 8'h08);
    chk(intr_req, 1'b0, "masked");
    {ext_irq, timer_out0} = 7'h01;
    io(16'h0021, 1'b1, 8'hfe);
    chk(intr_req, 1'b1, "timer");
    timer_out0 = 1'b0;
    io(16'h0021, 1'b1, 8'hbf);
    fdc_int_in = 1'b1;
    tick(4);
    chk(intr_req, 1'b1, "fdc int");
    io(16'h03f0, 1'b0, 8'h00);
    chk(intr_req, 1'b0, "fdc clear");
    // keyboard capture, clear, blocking
    io(16'h0021, 1'b1, 8'hfd);
    send(8'ha5);
    io(16'h0060, 1'b0, 8'h00);
    chk({keyboard_interrupt_req, intr_req, rd_val}, 10'h3a5, "kbd byte");
    io(16'h0061, 1'b1, 8'h80);
    chk(keyboard_interrupt_req, 1'b0, "kbd clear");
    io(16'h0061, 1'b1, 8'h40);
    send(8'h3c);
    chk(keyboard_interrupt_req, 1'b0, "kbd blocked");
    io(16'h0061, 1'b1, 8'h00);
    send(8'h5a);
    io(16'h0060, 1'b0, 8'h00);
    chk({keyboard_interrupt_req, rd_val}, 9'h15a, "kbd again");
    // wait states from either ready input
    for (int k = 1; k < 3; k++) begin
      {bus_addr, cyc_io, cyc_rd, io_ready_in, channel_ready_in} = {20'hff300, 2'b11, k[1:0]};
      tick(5);
      chk(cpu_ready, 1'b0, "wait");
      {io_ready_in, channel_ready_in} = 2'b11;
      tick(4);
      chk(cpu_ready, 1'b1, "ready");
      {cyc_io, cyc_rd} = 2'b00;
      tick(4);
    end
    // dma grant, lowest channel wins, terminal count
    dma_request_lines = 3'b110;
    tick(5);
    chk({dma_acknowledge_lines, dma_bus_owned}, 4'b0101, "grant");
    {bus_addr, cyc_mem, cyc_rd, channel_ready_in} = {20'h00100, 3'b110};
    tick(5);
    chk({dma_ready, mem_read_strobe}, 2'b01, "dma wait");
    channel_ready_in = 1'b1;
    tick(4);
    chk(dma_ready, 1'b1, "dma ready");
    dma_last_transfer = 1'b1;
    for (int i = 0; i < 8 && !terminal_count_out; i++) tick(1);
    chk(terminal_count_out, 1'b1, "tc");
    {cyc_mem, cyc_rd, dma_last_transfer, dma_request_lines} = '0;
    tick(6);
    chk({dma_acknowledge_lines, dma_bus_owned}, 4'b0000, "release");
    // floppy request rides channel two and drops on its acknowledge
    fdc_dma_in = 1'b1;
    for (int i = 0; i < 10 && dma_acknowledge_lines !== 3'b010; i++) tick(1);
    chk(dma_acknowledge_lines, 3'b010, "fdc grant");
    tick(3);
    chk(floppy_dma_request, 1'b0, "fdc drop");
    // head select and the two floppy clocks against 64 pin edges
    fdc_head_in = 1'b1;
    tick(4);
    {nf, nw} = '0;
    repeat (64) @(posedge clk16_in);
    tick(1);
    chk({head_side_select, nf >= 63 && nf <= 65, nw >= 3 && nw <= 5}, 3'b111, "clocks");
    complete_run();
  end
endmodule
